// >>> bench/bidir_fifo_bus_select_tb.sv
// Self-checking bench of the bus select block
`timescale 1ns/100ps
`include "bus_select_regs.svh"
module bidir_fifo_bus_select_tb;
  logic                  pclk = 1'b0;
  logic                  presetn = 1'b0;
  logic                  psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
  logic [11:0]           paddr = 12'h000;
  logic [31:0]           pwdata = 32'h0, prdata, rd;
  logic [3:0]            p = 4'h0, c, pn;
  bus_select_pkg::word_t ao, bo, ai, bi, pa = 9'h0, pb = 9'h0, sta = 9'h0, stb = 9'h0, v;
  logic                  aoe, boe;
  logic [1:0]            fl, rs;
  logic [19:0]           e;
  int                    fail_count = 0, comparisons = 0, seed = 54906;
  // Clock
  always #50 pclk = ~pclk;
  bus_select u_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .a_side_source_select(p[0]),
    .b_side_source_select(p[1]), .a_bus_output_enable(p[2]), .b_bus_output_enable(p[3]),
    .define_flag_a_n(fl[0]), .define_flag_b_n(fl[1]), .a_to_b_reset_n(rs[0]),
    .b_to_a_reset_n(rs[1]), .a_bus_in(ai), .a_bus_out(ao), .a_bus_oe(aoe), .b_bus_in(bi),
    .b_bus_out(bo), .b_bus_oe(boe), .a_store_word(sta), .b_store_word(stb));
  far_side u_far (.pclk(pclk), .a_bus_out(ao), .a_bus_oe(aoe), .b_bus_out(bo),
    .b_bus_oe(boe), .pa(pa), .pb(pb), .a_bus_in(ai), .b_bus_in(bi), .flag_n(fl), .rst_n(rs));
  // Register value compare
  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bus enable and drive word compare
  task automatic chk_bus(input string what, input logic [9:0] exp, input logic [9:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) fail_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Expected {a_oe, a_word, b_oe, b_word} for pins p and control bits k
  function automatic logic [19:0] exp_bus(input logic [3:0] q, input logic [3:0] k);
    logic                  sa, sb, ea, eb;
    bus_select_pkg::word_t ad, bd, bw;
    sa = q[0] | k[0];
    sb = q[1] | k[1];
    ea = q[2] & ~k[2];
    eb = q[3] & ~k[3];
    if (!ea) begin
      bd = sb ? sta : pa;
      bw = eb ? bd : pb;
      ad = sa ? stb : bw;
    end else if (!eb) begin
      ad = sa ? stb : pb;
      bd = sb ? sta : ad;
    end else begin
      bd = sb ? sta : stb;
      ad = sa ? stb : bd;
    end
    return {ea, ad, eb, bd};
  endfunction
  task automatic wrap_up();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    wrap_up();
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `CTRL_OFFSET, 32'h0);
    chk32("ctrl reset", 32'h0, rd);
    apb(1'b0, 12'h018, 32'h0);
    chk32("unmapped err", 32'h1, {31'h0, er});
    chk32("unmapped data", 32'h0, rd);
    $display("test registers done");
    for (int i = 0; i < 24; i++) begin
      p <= 4'h0;
      c = $random(seed);
      if (i < 2) c = 4'h0;
      apb(1'b1, `CTRL_OFFSET, {28'h0, c});
      apb(1'b0, `CTRL_OFFSET, 32'h0);
      chk32("ctrl", {28'h0, c}, rd);
      pn = $random(seed);
      if (i < 2) pn = i ? 4'h0 : 4'hf;
      if ((pn[2] & ~c[2]) & (pn[3] & ~c[3]) & ~(pn[0] | c[0]) & ~(pn[1] | c[1])) pn[1] = 1'b1;
      p <= pn;
      pa <= $random(seed);
      pb <= $random(seed);
      sta <= $random(seed);
      stb <= $random(seed);
      repeat (12) @(posedge pclk);
      e = exp_bus(p, c);
      chk_bus("a bus", e[19:10], {aoe, ao});
      chk_bus("b bus", e[9:0], {boe, bo});
    end
    $display("test bus select done");
    p <= 4'h0;
    apb(1'b1, `CTRL_OFFSET, 32'h0);
    apb(1'b0, `STATUS_OFFSET, 32'h0);
    chk32("status idle", 32'h0000000f, rd);
    apb(1'b0, `STORE_A_OFFSET, 32'h0);
    chk32("store a word", {23'h0, sta}, rd);
    apb(1'b0, `STORE_B_OFFSET, 32'h0);
    chk32("store b word", {23'h0, stb}, rd);
    for (int s = 0; s < 2; s++) begin
      v = $random(seed);
      if (s == 0) pa <= v;
      else pb <= v;
      repeat (4) @(posedge pclk);
      u_far.program_offset(s, 1'b1);
      apb(1'b0, s ? `OFFSET_B_OFFSET : `OFFSET_A_OFFSET, 32'h0);
      chk32("user offset", {23'h0, v}, rd);
      apb(1'b1, s ? `OFFSET_B_OFFSET : `OFFSET_A_OFFSET, 32'h0);
      apb(1'b0, s ? `OFFSET_B_OFFSET : `OFFSET_A_OFFSET, 32'h0);
      chk32("offset kept", {23'h0, v}, rd);
      u_far.program_offset(s, 1'b0);
      apb(1'b0, s ? `OFFSET_B_OFFSET : `OFFSET_A_OFFSET, 32'h0);
      chk32("default offset", {23'h0, `DEFAULT_OFFSET}, rd);
    end
    $display("test offsets done");
    wrap_up();
  end
endmodule

// >>> bench/far_side.sv
// Far-side bus controllers: bus wire levels and offset programming
`timescale 1ns/100ps
module far_side (
  input  wire logic                  pclk,
  input  wire bus_select_pkg::word_t a_bus_out,
  input  wire logic                  a_bus_oe,
  input  wire bus_select_pkg::word_t b_bus_out,
  input  wire logic                  b_bus_oe,
  input  wire bus_select_pkg::word_t pa,
  input  wire bus_select_pkg::word_t pb,
  output bus_select_pkg::word_t      a_bus_in,
  output bus_select_pkg::word_t      b_bus_in,
  output logic [1:0]                 flag_n,
  output logic [1:0]                 rst_n
);
  // Wire level: device drive wins, else this side drives its word
  assign a_bus_in = a_bus_oe ? a_bus_out : pa;
  assign b_bus_in = b_bus_oe ? b_bus_out : pb;
  // Flags and direction resets idle high
  initial begin
    flag_n = 2'h3;
    rst_n = 2'h3;
  end
  // One reset cycle of a direction, user word or default offset
  task automatic program_offset(input int s, input bit user);
    if (user) begin
      @(posedge pclk) flag_n[s] <= 1'b0;
    end
    repeat (4) @(posedge pclk);
    rst_n[s] <= 1'b0;
    repeat (4) @(posedge pclk);
    rst_n[s] <= 1'b1;
    repeat (4) @(posedge pclk);
    flag_n[s] <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
endmodule

// >>> shared/bus_select_pkg.sv
// Types shared by the bus select block
package bus_select_pkg;
  typedef logic [8:0] word_t;
  typedef enum logic {src_live, src_stored} src_t;
endpackage

// >>> shared/bus_select_regs.svh
// Register offsets, field positions and reset values of the bus select block
`ifndef BUS_SELECT_REGS_SVH
`define BUS_SELECT_REGS_SVH
`define CTRL_OFFSET       12'h000
`define STATUS_OFFSET     12'h004
`define OFFSET_A_OFFSET   12'h008
`define OFFSET_B_OFFSET   12'h00c
`define STORE_A_OFFSET    12'h010
`define STORE_B_OFFSET    12'h014
`define CTRL_A_SEL_BIT    0
`define CTRL_B_SEL_BIT    1
`define CTRL_A_OE_BIT     2
`define CTRL_B_OE_BIT     3
`define CTRL_RESET        4'h0
`define DEFAULT_OFFSET    9'h100
`define STATUS_A_RST_BIT  0
`define STATUS_B_RST_BIT  1
`define STATUS_A_DEF_BIT  2
`define STATUS_B_DEF_BIT  3
`define STATUS_A_SEL_BIT  4
`define STATUS_B_SEL_BIT  5
`endif

// >>> verilog/bus_select.sv
// Bus select top: pin synchronisers, APB registers, glitch-free source muxes, bus drivers
`timescale 1ns/100ps
`include "bus_select_regs.svh"
module bus_select (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  ce,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  a_side_source_select,
  input  wire logic                  b_side_source_select,
  input  wire logic                  a_bus_output_enable,
  input  wire logic                  b_bus_output_enable,
  input  wire logic                  define_flag_a_n,
  input  wire logic                  define_flag_b_n,
  input  wire logic                  a_to_b_reset_n,
  input  wire logic                  b_to_a_reset_n,
  input  wire bus_select_pkg::word_t a_bus_in,
  output bus_select_pkg::word_t      a_bus_out,
  output logic                       a_bus_oe,
  input  wire bus_select_pkg::word_t b_bus_in,
  output bus_select_pkg::word_t      b_bus_out,
  output logic                       b_bus_oe,
  input  wire bus_select_pkg::word_t a_store_word,
  input  wire bus_select_pkg::word_t b_store_word
);
  logic [7:0]            pins_s;
  logic [17:0]           data_s;
  bus_select_pkg::word_t a_live;
  bus_select_pkg::word_t b_live;
  bus_select_pkg::word_t offset_a;
  bus_select_pkg::word_t offset_b;
  logic [3:0]            ctrl_q;
  logic [3:0]            ctrl_d;
  logic [31:0]           prdata_d;
  logic                  pready_d;
  logic                  pslverr_d;
  logic                  access;
  bus_select_pkg::src_t  a_src;
  bus_select_pkg::src_t  b_src;
  bus_select_pkg::word_t a_out_d;
  bus_select_pkg::word_t b_out_d;
  logic                  a_oe_d;
  logic                  b_oe_d;

  // Control and reset pins enter through two flops
  pin_sync #(.WIDTH(8)) u_pin_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .pin_in   ({a_side_source_select, b_side_source_select, a_bus_output_enable,
                b_bus_output_enable, define_flag_a_n, define_flag_b_n,
                a_to_b_reset_n, b_to_a_reset_n}),
    .rst_val  (8'h3f),
    .sync_out (pins_s)
  );

  // Live bus data also crosses in from the pins
  pin_sync #(.WIDTH(18)) u_data_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .pin_in   ({a_bus_in, b_bus_in}),
    .rst_val  (18'h00000),
    .sync_out (data_s)
  );
  assign a_live = data_s[17:9];
  assign b_live = data_s[8:0];

  // Offset for the store loaded from the A side
  offset_capture u_offset_a (
    .pclk          (pclk),
    .presetn       (presetn),
    .ce            (ce),
    .define_flag_n (pins_s[3]),
    .dir_reset_n   (pins_s[1]),
    .side_data     (a_live),
    .offset        (offset_a)
  );

  // Offset for the store loaded from the B side
  offset_capture u_offset_b (
    .pclk          (pclk),
    .presetn       (presetn),
    .ce            (ce),
    .define_flag_n (pins_s[2]),
    .dir_reset_n   (pins_s[0]),
    .side_data     (b_live),
    .offset        (offset_b)
  );

  // APB slave, one wait state, error on unmapped address
  assign access = psel && penable && !pready;
  always_comb begin
    ctrl_d    = ctrl_q;
    prdata_d  = 32'h00000000;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    if (access) begin
      pready_d = 1'b1;
      case (paddr)
        `CTRL_OFFSET: begin
          prdata_d = {28'h0000000, ctrl_q};
        end
        `STATUS_OFFSET: begin
          prdata_d = {26'h0000000, b_src == bus_select_pkg::src_stored,
                      a_src == bus_select_pkg::src_stored,
                      pins_s[2], pins_s[3], pins_s[0], pins_s[1]};
        end
        `OFFSET_A_OFFSET: prdata_d = {23'h000000, offset_a};
        `OFFSET_B_OFFSET: prdata_d = {23'h000000, offset_b};
        `STORE_A_OFFSET:  prdata_d = {23'h000000, a_store_word};
        `STORE_B_OFFSET:  prdata_d = {23'h000000, b_store_word};
        default:          pslverr_d = 1'b1;
      endcase
      if (pwrite && paddr != `CTRL_OFFSET) begin
        prdata_d = 32'h00000000;
      end
    end
    // Write lands at the edge where the master sees pready high
    if (psel && penable && pready && pwrite && paddr == `CTRL_OFFSET) begin
      ctrl_d = pwdata[3:0];
    end
  end

  // Selects: pin OR register bit; enables: pin AND NOT register bit
  always_comb begin
    a_src = (pins_s[7] | ctrl_q[`CTRL_A_SEL_BIT]) ? bus_select_pkg::src_stored
                                                   : bus_select_pkg::src_live;
    b_src = (pins_s[6] | ctrl_q[`CTRL_B_SEL_BIT]) ? bus_select_pkg::src_stored
                                                   : bus_select_pkg::src_live;
    a_oe_d = pins_s[5] & ~ctrl_q[`CTRL_A_OE_BIT];
    b_oe_d = pins_s[4] & ~ctrl_q[`CTRL_B_OE_BIT];
    case (a_src)
      bus_select_pkg::src_stored: a_out_d = b_store_word;
      default:                    a_out_d = b_live;
    endcase
    case (b_src)
      bus_select_pkg::src_stored: b_out_d = a_store_word;
      default:                    b_out_d = a_live;
    endcase
  end

  // Registered mux outputs switch in one edge, no mixed word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q    <= `CTRL_RESET;
      prdata    <= 32'h00000000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      a_bus_out <= 9'h000;
      b_bus_out <= 9'h000;
      a_bus_oe  <= 1'b0;
      b_bus_oe  <= 1'b0;
    end else if (ce) begin
      ctrl_q    <= ctrl_d;
      prdata    <= prdata_d;
      pready    <= pready_d;
      pslverr   <= pslverr_d;
      a_bus_out <= a_out_d;
      b_bus_out <= b_out_d;
      a_bus_oe  <= a_oe_d;
      b_bus_oe  <= b_oe_d;
    end
  end

  a_a_source: assert property (@(posedge pclk) disable iff (!presetn)
    ce |=> a_bus_out == ($past(a_src) == bus_select_pkg::src_stored ?
                         $past(b_store_word) : $past(b_live)))
    else $error("A bus source wrong");
  a_b_source: assert property (@(posedge pclk) disable iff (!presetn)
    ce |=> b_bus_out == ($past(b_src) == bus_select_pkg::src_stored ?
                         $past(a_store_word) : $past(a_live)))
    else $error("B bus source wrong");
  a_b_enable: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !pins_s[4] |=> !b_bus_oe)
    else $error("B bus driven while disabled");
  a_a_enable: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !pins_s[5] |=> !a_bus_oe)
    else $error("A bus driven while disabled");
  a_clean_switch: assert property (@(posedge pclk) disable iff (!presetn)
    ce && $changed(a_src) && $stable(b_live) && $stable(b_store_word)
    ##1 ce && $stable(a_src) && $stable(b_live) && $stable(b_store_word)
    |=> $stable(a_bus_out))
    else $error("A bus changed twice after select switch");
  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    ce && psel && penable && !pready |=> pready ##1 !pready)
    else $error("APB ready not a single pulse");
  c_a_stored: cover property (@(posedge pclk) disable iff (!presetn)
    a_src == bus_select_pkg::src_stored && a_bus_oe);
  c_b_stored: cover property (@(posedge pclk) disable iff (!presetn)
    b_src == bus_select_pkg::src_stored && b_bus_oe);
  c_apb_write: cover property (@(posedge pclk) disable iff (!presetn)
    pready && pwrite && paddr == `CTRL_OFFSET);
endmodule

// >>> verilog/offset_capture.sv
// Almost-full/almost-empty offset capture for one direction
`timescale 1ns/100ps
module offset_capture (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  ce,
  input  wire logic                  define_flag_n,
  input  wire logic                  dir_reset_n,
  input  wire bus_select_pkg::word_t side_data,
  output bus_select_pkg::word_t      offset
);
  logic                  flag_q;
  logic                  flag_d;
  logic                  rst_q;
  logic                  rst_d;
  logic                  held_high_q;
  logic                  held_high_d;
  bus_select_pkg::word_t user_q;
  bus_select_pkg::word_t user_d;
  bus_select_pkg::word_t offset_q;
  bus_select_pkg::word_t offset_d;

  // Edge detection and offset selection
  always_comb begin
    flag_d      = define_flag_n;
    rst_d       = dir_reset_n;
    user_d      = user_q;
    held_high_d = held_high_q;
    offset_d    = offset_q;
    if (flag_q && !define_flag_n) begin
      user_d = side_data;
    end
    if (rst_q && !dir_reset_n) begin
      held_high_d = define_flag_n;
    end else if (!dir_reset_n) begin
      held_high_d = held_high_q & define_flag_n;
    end
    if (!rst_q && dir_reset_n) begin
      offset_d = (held_high_q && define_flag_n) ? `DEFAULT_OFFSET : user_d;
    end
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q      <= 1'b1;
      rst_q       <= 1'b1;
      held_high_q <= 1'b1;
      user_q      <= `DEFAULT_OFFSET;
      offset_q    <= `DEFAULT_OFFSET;
    end else if (ce) begin
      flag_q      <= flag_d;
      rst_q       <= rst_d;
      held_high_q <= held_high_d;
      user_q      <= user_d;
      offset_q    <= offset_d;
    end
  end

  assign offset = offset_q;

  a_user_capture: assert property (@(posedge pclk) disable iff (!presetn)
    ce && flag_q && !define_flag_n |=> user_q == $past(side_data))
    else $error("offset word not captured on define flag fall");
  a_default_offset: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !rst_q && dir_reset_n && held_high_q && define_flag_n
    |=> offset_q == `DEFAULT_OFFSET)
    else $error("default offset not applied");
  c_user_release: cover property (@(posedge pclk) disable iff (!presetn)
    ce && !rst_q && dir_reset_n && !define_flag_n);
endmodule

// >>> verilog/pin_sync.sv
// Two-stage synchroniser for a group of pin levels
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] pin_in,
  input  wire logic [WIDTH-1:0] rst_val,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;
  logic [WIDTH-1:0] init_q;

  // Next values, frozen while the enable is low
  always_comb begin
    meta_d = ce ? pin_in : meta_q;
    sync_d = ce ? meta_q : sync_q;
  end

  // Reset value is strapped per instance, applied after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
      init_q <= '0;
    end else begin
      init_q <= '1;
      meta_q <= meta_d;
      sync_q <= init_q == '0 ? rst_val : sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule
